// ---- verilog/daqsc_pkg.sv ----
package daqsc_pkg;
  localparam int          CLK_HZ          = 10_000_000;
  localparam int          CH_NUM          = 8;
  localparam int          SMP_W           = 16;
  localparam int          MEM_DEPTH       = 32768;
  localparam int          PTR_W           = 15;
  localparam int          CH_MAX_SPS      = 100_000;
  localparam int          AGG_HW_SPS      = 400_000;
  localparam int          AGG_BURST_SPS   = 800_000;
  localparam int          SYNC_MAX_HZ     = 100_000;
  localparam int          CH_MIN_CYC      = CLK_HZ / CH_MAX_SPS;
  localparam int          HW_HALF_PER_CH  = 2 * CLK_HZ / AGG_HW_SPS;
  localparam int          BU_HALF_PER_CH  = 2 * CLK_HZ / AGG_BURST_SPS;
  localparam int          SYNC_MIN_CYC    = CLK_HZ / SYNC_MAX_HZ;
  localparam longint      LED_BLINK_NS    = 50_000_000;
  localparam int          LED_BLINK_CYC   = int'(LED_BLINK_NS / 100);
  localparam logic [7:0]  ADR_CMD         = 8'h00;
  localparam logic [7:0]  ADR_CFG         = 8'h04;
  localparam logic [7:0]  ADR_CHMASK      = 8'h08;
  localparam logic [7:0]  ADR_RANGE       = 8'h0C;
  localparam logic [7:0]  ADR_RATE        = 8'h10;
  localparam logic [7:0]  ADR_STATUS      = 8'h14;
  localparam logic [7:0]  ADR_SWDATA      = 8'h18;
  localparam logic [7:0]  ADR_FIFO        = 8'h1C;
  localparam int          CMD_START       = 0;
  localparam int          CMD_STOP        = 1;
  localparam int          CMD_SWCONV      = 2;
  localparam int          CMD_CLEAR       = 3;
  localparam int          CFG_BURST       = 0;
  localparam int          CFG_EXTCLK      = 1;
  localparam int          CFG_TRIG_EN     = 2;
  localparam int          CFG_TMODE_LSB   = 3;
  localparam int          CFG_SYNC_OUT    = 5;
  localparam int          CFG_SWCH_LSB    = 8;
  localparam logic [31:0] CFG_RST         = 32'h0000_0000;
  localparam logic [7:0]  CHMASK_RST      = 8'h01;
  localparam logic [15:0] RANGE_RST       = 16'h0000;
  localparam logic [15:0] RATE_RST        = 16'h0064;
  localparam logic [1:0]  RANGE_PM10      = 2'h0;
  localparam logic [1:0]  RANGE_PM5       = 2'h1;
  localparam logic [1:0]  RANGE_PM2       = 2'h2;
  localparam logic [1:0]  RANGE_PM1       = 2'h3;
  localparam logic [1:0]  TRIG_RISE       = 2'h0;
  localparam logic [1:0]  TRIG_FALL       = 2'h1;
  localparam logic [1:0]  TRIG_HIGH       = 2'h2;
  localparam logic [1:0]  TRIG_LOW        = 2'h3;
  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_SLVERR     = 2'h2;
endpackage

// ---- verilog/daqsc_pacer.sv ----
`timescale 1ns/1ps
module daqsc_pacer
  import daqsc_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        run_i,
  input  wire logic        ext_clk_i,
  input  wire logic [15:0] period_i,
  input  wire logic        sync_i,
  input  wire logic        trig_i,
  input  wire logic [1:0]  trig_mode_i,
  output logic             tick_o,
  output logic             trig_hit_o
);
  logic [15:0] cnt;
  logic        sync_q;
  logic        trig_q;
  wire         int_tick = run_i && !ext_clk_i && (cnt >= period_i - 16'h0001);
  wire         ext_tick = run_i && ext_clk_i && sync_i && !sync_q;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      cnt    <= 16'h0000;
      sync_q <= 1'b0;
      trig_q <= 1'b0;
    end else begin
      sync_q <= sync_i;
      trig_q <= trig_i;
      cnt    <= (!run_i || int_tick) ? 16'h0000 : cnt + 16'h0001;
    end
  end

  assign tick_o = int_tick || ext_tick; // RL4

  always_comb begin
    unique case (trig_mode_i) // RL19
      TRIG_RISE: trig_hit_o = trig_i && !trig_q;
      TRIG_FALL: trig_hit_o = !trig_i && trig_q;
      TRIG_HIGH: trig_hit_o = trig_i;
      TRIG_LOW:  trig_hit_o = !trig_i;
    endcase
  end
endmodule // daqsc_pacer

// ---- verilog/daqsc_led.sv ----
`timescale 1ns/1ps
module daqsc_led
  import daqsc_pkg::*;
#(
  parameter int BLINK_CYC = LED_BLINK_CYC
) (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic host_up_i,
  input  wire logic cmd_i,
  input  wire logic scan_i,
  output logic      led_o
);
  logic [31:0] cnt;
  logic        once;
  logic        phase;
  wire         wrap = (cnt >= 32'(BLINK_CYC - 1));

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      cnt   <= 32'h0000_0000;
      once  <= 1'b0;
      phase <= 1'b0;
      led_o <= 1'b0;
    end else begin
      cnt <= (wrap || (cmd_i && !once)) ? 32'h0000_0000 : cnt + 32'h0000_0001;
      if (cmd_i && !once) begin
        once <= 1'b1; // RL14
      end else if (wrap) begin
        once <= 1'b0;
      end
      if (wrap) begin
        phase <= !phase;
      end
      if (!host_up_i) begin
        led_o <= 1'b0; // RL16
      end else if (scan_i) begin
        led_o <= phase; // RL15
      end else begin
        led_o <= !once; // RL13
      end
    end
  end
endmodule // daqsc_led

// ---- verilog/daqsc_top.sv ----
`timescale 1ns/1ps
// Notes on behaviour
// [RL1] Each software conversion gives one sample, read back before the next starts.
// [RL2] Paced scans sample every selected channel at one instant, one to eight.
// [RL3] Paced scans push words into the memory queue until stopped; host drains them.
// [RL4] Pacing tick comes from the internal rate counter or the sync terminal.
// [RL5] Paced rate limited by aggregate over channel count and per-channel ceiling.
// [RL6] Paced scan starts on host command, optionally waiting for the trigger.
// [RL7] Burst fills the whole memory; data readable only after capture completes.
// [RL8] Burst is one sequence over one to eight channels, optionally triggered.
// [RL9] Burst sample total is capped at the memory depth.
// [RL10] Burst aggregate rate limited, each channel up to the per-channel ceiling.
// [RL11] Eight converters of 16 bits, all launched together.
// [RL12] Host sets a two-bit range code per channel, four ranges.
// [RL13] Status light steady on while the host link is up.
// [RL14] Status light blinks once for each host command; code blinks per register write outside scans, not during a blink.
// [RL15] Status light blinks during a scan, steady again afterwards.
// [RL16] Status light off while the host link is lost.
// [RL17] Sync terminal is bidirectional, supplying or accepting the pacing clock.
// [RL18] Sync terminal defaults to input and accepts edges up to 100 kHz.
// [RL19] Trigger is rising, falling, high or low sensitive by software choice.
// [RL20] Host loads at most eight increasing channel entries, each with its range.
// [RL21] A full queue in a paced scan stops it and sets a sticky overrun flag.
// [RL22] Scan requests beyond mode limits are refused and acquisition stays idle.
module daqsc_top
  import daqsc_pkg::*;
#(
  parameter int BLINK_CYC = LED_BLINK_CYC
) (
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  input  wire logic [7:0]   s_axi_awaddr_i,
  input  wire logic         s_axi_awvalid_i,
  output logic              s_axi_awready_o,
  input  wire logic [31:0]  s_axi_wdata_i,
  input  wire logic [3:0]   s_axi_wstrb_i,
  input  wire logic         s_axi_wvalid_i,
  output logic              s_axi_wready_o,
  output logic [1:0]        s_axi_bresp_o,
  output logic              s_axi_bvalid_o,
  input  wire logic         s_axi_bready_i,
  input  wire logic [7:0]   s_axi_araddr_i,
  input  wire logic         s_axi_arvalid_i,
  output logic              s_axi_arready_o,
  output logic [31:0]       s_axi_rdata_o,
  output logic [1:0]        s_axi_rresp_o,
  output logic              s_axi_rvalid_o,
  input  wire logic         s_axi_rready_i,
  output logic              adc_start_o,
  input  wire logic         adc_done_i,
  input  wire logic [127:0] adc_data_i,
  output logic [15:0]       range_code_o,
  input  wire logic         sync_i,
  output logic              sync_o,
  output logic              sync_oe_o,
  input  wire logic         external_trigger_terminal_i,
  input  wire logic         host_up_i,
  output logic              status_led_o
);
  typedef enum logic [2:0] {ST_IDLE, ST_ARM, ST_RUN, ST_CONV, ST_PUSH, ST_SWCONV} daqsc_state_t;

  function automatic logic [31:0] apply_strb(input logic [31:0] old, input logic [31:0] val,
                                             input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[8*b +: 8] = val[8*b +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [3:0] popcnt(input logic [7:0] m);
    logic [3:0] c;
    c = 4'h0;
    for (int i = 0; i < CH_NUM; i++) begin
      c = c + {3'h0, m[i]};
    end
    return c;
  endfunction

  daqsc_state_t      st;
  logic [15:0]       smp [CH_NUM];
  logic [15:0]       lat [CH_NUM];
  logic [15:0]       mem [MEM_DEPTH];
  logic [15:0]       mem_q;
  logic [PTR_W-1:0]  wr_ptr;
  logic [PTR_W-1:0]  rd_ptr;
  logic [PTR_W:0]    level;
  logic [2:0]        ch_idx;
  logic [31:0]       cfg;
  logic [7:0]        chmask;
  logic [15:0]       rate;
  logic [15:0]       sw_data;
  logic              sw_valid;
  logic              sw_pend;
  logic              stop_pend;
  logic              ovr;
  logic              rej;
  logic              bdone;
  logic              aw_got;
  logic              w_got;
  logic [7:0]        aw_adr;
  logic [31:0]       w_dat;
  logic [3:0]        w_stb;
  logic              tick;
  logic              trig_hit;

  genvar g;
  for (g = 0; g < CH_NUM; g++) begin : g_ch
    assign smp[g] = adc_data_i[SMP_W*g +: SMP_W]; // RL11
  end

  wire         aw_fire   = s_axi_awvalid_i && s_axi_awready_o;
  wire         w_fire    = s_axi_wvalid_i && s_axi_wready_o;
  wire         b_fire    = s_axi_bvalid_o && s_axi_bready_i;
  wire         ar_fire   = s_axi_arvalid_i && s_axi_arready_o;
  wire         r_fire    = s_axi_rvalid_o && s_axi_rready_i;
  wire         wr_do     = aw_got && w_got && !s_axi_bvalid_o;
  wire         wr_cmd    = wr_do && (aw_adr == ADR_CMD) && w_stb[0];
  wire         start_cmd = wr_cmd && w_dat[CMD_START];
  wire         stop_cmd  = wr_cmd && w_dat[CMD_STOP];
  wire         sw_cmd    = wr_cmd && w_dat[CMD_SWCONV];
  wire         clr_cmd   = wr_cmd && w_dat[CMD_CLEAR];
  wire         wr_map    = (aw_adr <= ADR_FIFO) && (aw_adr[1:0] == 2'h0);
  wire         rd_map    = (s_axi_araddr_i <= ADR_FIFO) && (s_axi_araddr_i[1:0] == 2'h0);
  wire         is_burst  = cfg[CFG_BURST];
  wire         ext_clk   = cfg[CFG_EXTCLK];
  wire [1:0]   tmode     = cfg[CFG_TMODE_LSB +: 2];
  wire [2:0]   sw_ch     = cfg[CFG_SWCH_LSB +: 3];
  wire         active    = (st != ST_IDLE) && (st != ST_SWCONV);
  wire [3:0]   nch       = popcnt(chmask);
  wire [20:0]  rate2     = {4'h0, rate, 1'b0};
  wire [20:0]  need_hw   = 21'(nch * HW_HALF_PER_CH);
  wire [20:0]  need_bu   = 21'(nch * BU_HALF_PER_CH);
  wire         rate_ok   = ext_clk || ((rate >= 16'(CH_MIN_CYC))
                           && (rate2 >= (is_burst ? need_bu : need_hw))); // RL5 RL10
  wire         scan_ok   = (nch != 4'h0) && rate_ok; // RL22 RL8
  wire         full      = (level == (PTR_W+1)'(MEM_DEPTH));
  wire         push      = (st == ST_PUSH) && chmask[ch_idx] && !full;
  wire         push_full = (st == ST_PUSH) && chmask[ch_idx] && full;
  wire         rd_fifo   = ar_fire && (s_axi_araddr_i == ADR_FIFO);
  wire         fifo_open = !(is_burst && active); // RL7
  wire         pop       = rd_fifo && fifo_open && (level != '0);
  wire         rd_sw     = ar_fire && (s_axi_araddr_i == ADR_SWDATA);
  wire [31:0]  stat_word = {1'b0, level, 9'h000, (st == ST_ARM), sw_valid, bdone, rej, ovr,
                            active};

  daqsc_pacer u_pacer (
    .clk_i       (clk_i),
    .rst_n_i     (rst_n_i),
    .run_i       (st != ST_IDLE && st != ST_ARM && st != ST_SWCONV),
    .ext_clk_i   (ext_clk),
    .period_i    (rate),
    .sync_i      (sync_i),
    .trig_i      (external_trigger_terminal_i),
    .trig_mode_i (tmode),
    .tick_o      (tick),
    .trig_hit_o  (trig_hit)
  );

  daqsc_led #(.BLINK_CYC(BLINK_CYC)) u_led (
    .clk_i     (clk_i),
    .rst_n_i   (rst_n_i),
    .host_up_i (host_up_i),
    .cmd_i     (wr_do),
    .scan_i    (active),
    .led_o     (status_led_o)
  );

  logic [31:0] rd_val;
  always_comb begin
    unique case (s_axi_araddr_i)
      ADR_CFG:    rd_val = cfg;
      ADR_CHMASK: rd_val = {24'h000000, chmask};
      ADR_RANGE:  rd_val = {16'h0000, range_code_o};
      ADR_RATE:   rd_val = {16'h0000, rate};
      ADR_STATUS: rd_val = stat_word;
      ADR_SWDATA: rd_val = {16'h0000, sw_data};
      ADR_FIFO:   rd_val = {16'h0000, pop ? mem_q : 16'h0000};
      default:    rd_val = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      s_axi_awready_o <= 1'b1;
      s_axi_wready_o  <= 1'b1;
      s_axi_bvalid_o  <= 1'b0;
      s_axi_bresp_o   <= RESP_OKAY;
      s_axi_arready_o <= 1'b1;
      s_axi_rvalid_o  <= 1'b0;
      s_axi_rresp_o   <= RESP_OKAY;
      s_axi_rdata_o   <= 32'h0000_0000;
      aw_got          <= 1'b0;
      w_got           <= 1'b0;
      aw_adr          <= 8'h00;
      w_dat           <= 32'h0000_0000;
      w_stb           <= 4'h0;
      cfg             <= CFG_RST;
      chmask          <= CHMASK_RST;
      range_code_o    <= RANGE_RST;
      rate            <= RATE_RST;
    end else begin
      if (aw_fire) begin
        aw_got          <= 1'b1;
        aw_adr          <= s_axi_awaddr_i;
        s_axi_awready_o <= 1'b0;
      end
      if (w_fire) begin
        w_got          <= 1'b1;
        w_dat          <= s_axi_wdata_i;
        w_stb          <= s_axi_wstrb_i;
        s_axi_wready_o <= 1'b0;
      end
      if (wr_do) begin
        aw_got         <= 1'b0;
        w_got          <= 1'b0;
        s_axi_bvalid_o <= 1'b1;
        s_axi_bresp_o  <= wr_map ? RESP_OKAY : RESP_SLVERR;
        unique case (aw_adr)
          ADR_CFG:    cfg <= apply_strb(cfg, w_dat, w_stb);
          ADR_CHMASK: chmask <= w_stb[0] ? w_dat[7:0] : chmask; // RL20
          ADR_RANGE:  range_code_o <= 16'(apply_strb({16'h0000, range_code_o}, w_dat, w_stb)); // RL12
          ADR_RATE:   rate <= 16'(apply_strb({16'h0000, rate}, w_dat, w_stb));
          default:    ;
        endcase
      end
      if (b_fire) begin
        s_axi_bvalid_o  <= 1'b0;
        s_axi_awready_o <= 1'b1;
        s_axi_wready_o  <= 1'b1;
      end
      if (ar_fire) begin
        s_axi_arready_o <= 1'b0;
        s_axi_rvalid_o  <= 1'b1;
        s_axi_rdata_o   <= rd_val;
        s_axi_rresp_o   <= (!rd_map || (rd_fifo && !fifo_open)) ? RESP_SLVERR : RESP_OKAY;
      end
      if (r_fire) begin
        s_axi_rvalid_o  <= 1'b0;
        s_axi_arready_o <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wr_ptr] <= lat[ch_idx]; // RL3
    end
    mem_q <= mem[rd_ptr];
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      st          <= ST_IDLE;
      wr_ptr      <= '0;
      rd_ptr      <= '0;
      level       <= '0;
      ch_idx      <= 3'h0;
      sw_data     <= 16'h0000;
      sw_valid    <= 1'b0;
      sw_pend     <= 1'b0;
      stop_pend   <= 1'b0;
      ovr         <= 1'b0;
      rej         <= 1'b0;
      bdone       <= 1'b0;
      adc_start_o <= 1'b0;
      sync_o      <= 1'b0;
      sync_oe_o   <= 1'b0;
      for (int i = 0; i < CH_NUM; i++) begin
        lat[i] <= 16'h0000;
      end
    end else begin
      adc_start_o <= 1'b0;
      sync_oe_o   <= cfg[CFG_SYNC_OUT] && !ext_clk; // RL17 RL18
      sync_o      <= cfg[CFG_SYNC_OUT] && !ext_clk && tick;
      wr_ptr      <= wr_ptr + PTR_W'(push);
      rd_ptr      <= rd_ptr + PTR_W'(pop);
      level       <= level + (PTR_W+1)'(push) - (PTR_W+1)'(pop);
      if (sw_cmd) begin
        sw_pend <= 1'b1;
      end
      if (rd_sw && !(st == ST_SWCONV && adc_done_i)) begin
        sw_valid <= 1'b0;
      end
      if (clr_cmd) begin
        ovr   <= 1'b0;
        rej   <= 1'b0;
        bdone <= 1'b0;
      end
      if (stop_cmd && active) begin
        stop_pend <= 1'b1;
      end
      unique case (st)
        ST_IDLE: begin
          stop_pend <= 1'b0;
          if (start_cmd && scan_ok) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            level  <= '0;
            bdone  <= 1'b0;
            st     <= cfg[CFG_TRIG_EN] ? ST_ARM : ST_RUN; // RL6 RL8
          end else if (start_cmd) begin
            rej <= 1'b1; // RL22
          end else if (sw_pend && !sw_valid && !sw_cmd) begin
            sw_pend     <= 1'b0;
            adc_start_o <= 1'b1; // RL1
            st          <= ST_SWCONV;
          end
        end
        ST_ARM: begin
          if (stop_cmd || stop_pend) begin
            st <= ST_IDLE;
          end else if (trig_hit) begin
            st <= ST_RUN; // RL6
          end
        end
        ST_RUN: begin
          if (stop_cmd || stop_pend) begin
            st <= ST_IDLE;
          end else if (tick) begin
            adc_start_o <= 1'b1; // RL2 RL11
            st          <= ST_CONV;
          end
        end
        ST_CONV: begin
          if (adc_done_i) begin
            for (int i = 0; i < CH_NUM; i++) begin
              lat[i] <= smp[i];
            end
            ch_idx <= 3'h0;
            st     <= ST_PUSH;
          end
        end
        ST_PUSH: begin
          ch_idx <= ch_idx + 3'h1;
          if (push_full && !is_burst) begin
            ovr <= 1'b1; // RL21
            st  <= ST_IDLE;
          end else if (push_full) begin
            bdone <= 1'b1; // RL9
            st    <= ST_IDLE;
          end else if (ch_idx == 3'h7) begin
            st <= ST_RUN;
          end
        end
        ST_SWCONV: begin
          if (adc_done_i) begin
            sw_data  <= smp[sw_ch];
            sw_valid <= 1'b1; // RL1
            st       <= ST_IDLE;
          end
        end
      endcase
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  chk_sw_result_held: assert property ( // RL1
    (st == ST_SWCONV && adc_done_i) |=> sw_valid && st == ST_IDLE
  ) else $error("software sample not held for the host");
  chk_sw_no_overlap: assert property ( // RL1
    (sw_valid && st == ST_IDLE && !rd_sw) |=> st != ST_SWCONV
  ) else $error("conversion started before previous sample read");
  chk_tick_launch: assert property ( // RL2
    (st == ST_RUN && tick && !stop_cmd && !stop_pend) |=> adc_start_o ##1 !adc_start_o
  ) else $error("pacing tick did not launch converters once");
  chk_reject_idle: assert property ( // RL22
    (st == ST_IDLE && start_cmd && !scan_ok) |=> st == ST_IDLE && rej
  ) else $error("out of limit scan was not refused");
  chk_overrun_stop: assert property ( // RL21
    (push_full && !is_burst) |=> ovr && st == ST_IDLE && !adc_start_o
  ) else $error("full queue did not stop the paced scan");
  chk_burst_cap: assert property ( // RL9
    level <= (PTR_W+1)'(MEM_DEPTH)
  ) else $error("queue level above memory depth");
  chk_burst_no_drain: assert property ( // RL7
    (is_burst && active) |-> !pop
  ) else $error("burst data drained before capture ended");
  chk_trig_wait: assert property ( // RL6
    (st == ST_ARM && !trig_hit) |=> (st == ST_ARM || st == ST_IDLE) && !adc_start_o
  ) else $error("conversion before trigger");
  chk_sync_input: assert property ( // RL18
    !cfg[CFG_SYNC_OUT] |=> !sync_oe_o && !sync_o
  ) else $error("sync terminal driven while set as input");

  cov_sw_conv:   cover property (st == ST_SWCONV ##[1:20] sw_valid);
  cov_burst_end: cover property (push_full && is_burst);
  cov_overrun:   cover property (push_full && !is_burst);
endmodule // daqsc_top

// ---- test/daqsc_adc_model.sv ----
`timescale 1ns/1ps
module daqsc_adc_model #(
  parameter int LAT = 4
) (
  input  wire logic   clk_i,
  input  wire logic   rst_n_i,
  input  wire logic   start_i,
  output logic        done_o,
  output logic [127:0] data_o
);
  logic [3:0]  wait_q;
  logic        busy;
  logic [11:0] n;
  // Answers alternate slow and fast, starting slow; data is valid only in the done cycle.
  always_ff @(posedge clk_i) begin
    done_o <= 1'b0;
    if (!rst_n_i) begin
      busy <= 1'b0;
      wait_q <= 4'h0;
      n <= 12'h000;
      data_o <= '0;
    end else if (start_i && !busy) begin
      busy <= 1'b1;
      wait_q <= n[0] ? 4'h1 : 4'(LAT);
      data_o <= ~data_o;
    end else if (busy && wait_q == 4'h1) begin
      busy <= 1'b0;
      done_o <= 1'b1;
      n <= n + 12'h001;
      for (int k = 0; k < 8; k++) begin
        data_o[16*k +: 16] <= {4'(k), n};
      end
    end else begin
      wait_q <= wait_q - 4'h1;
      data_o <= ~data_o;
    end
  end
endmodule // daqsc_adc_model

// ---- test/testbench.sv ----
`timescale 1ns/1ps
module testbench;
  import daqsc_pkg::*;
  logic         clk = 1'b0;
  logic         rst_n = 1'b0;
  logic         host_up = 1'b0;
  logic         trig = 1'b0;
  logic [7:0]   awaddr = 8'h00;
  logic [7:0]   araddr = 8'h00;
  logic [31:0]  wdata = 32'h0;
  logic         awvalid = 1'b0;
  logic         wvalid = 1'b0;
  logic         bready = 1'b0;
  logic         arvalid = 1'b0;
  logic         rready = 1'b0;
  logic         awready, wready, bvalid, arready, rvalid;
  logic         adc_start, adc_done, sync_o, sync_oe, led;
  logic [1:0]   bresp, rresp, rsp;
  logic [31:0]  rdata, rd;
  logic [127:0] adc_data;
  logic [15:0]  range_code;
  logic         sync_drv = 1'b0;
  wire          sync_line = sync_oe ? sync_o : sync_drv;
  int           errors = 0;
  int           syncs = 0;
  int           checks_done = 0;
  int           starts = 0;
  always #50 clk = ~clk;
  always @(posedge clk) if (adc_start === 1'b1) starts <= starts + 1;
  always @(posedge clk) if ((sync_oe & sync_o) === 1'b1) syncs <= syncs + 1;
  daqsc_top #(.BLINK_CYC(8)) daqsc_top_inst (
    .clk_i(clk), .rst_n_i(rst_n), .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
    .s_axi_awready_o(awready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hF),
    .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
    .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready), .s_axi_araddr_i(araddr),
    .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
    .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
    .adc_start_o(adc_start), .adc_done_i(adc_done), .adc_data_i(adc_data),
    .range_code_o(range_code), .sync_i(sync_line), .sync_o(sync_o), .sync_oe_o(sync_oe),
    .external_trigger_terminal_i(trig), .host_up_i(host_up), .status_led_o(led));
  daqsc_adc_model daqsc_adc_model_inst (
    .clk_i(clk), .rst_n_i(rst_n), .start_i(adc_start), .done_o(adc_done), .data_o(adc_data));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run;
    $display("Checks %0d, mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid === 1'b1) break;
    end
    bready <= 1'b0;
    rsp = bresp;
    if (n == 50) errors++;
    if (n == 50) complete_run();
  endtask
  task automatic rdr(input logic [7:0] a);
    int n;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    rready <= 1'b0;
    rd = rdata;
    rsp = rresp;
    if (n == 50) errors++;
    if (n == 50) complete_run();
  endtask
  task automatic poll(input int b, input logic v);
    for (int n = 0; n < 100; n++) begin
      rdr(ADR_STATUS);
      if (rd[b] === v) break;
    end
    check(32'(rd[b]), 32'(v));
  endtask
  initial begin
    automatic logic [7:0] ra[7] = '{ADR_CMD, ADR_CFG, ADR_CHMASK, ADR_RANGE, ADR_RATE,
                                    8'h20, 8'h06};
    automatic logic [31:0] rv[5] = '{32'h0, 32'h0, 32'h1, 32'h0, 32'h64};
    automatic logic [7:0] mk[3] = '{8'h00, 8'h01, 8'hFF};
    automatic logic [15:0] rt[3] = '{16'h64, 16'h63, 16'hC7};
    int tg, s0, lvl;
    logic pl;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    cyc(1);
    check(32'(sync_oe), 32'h0);
    check(32'(led), 32'h0);
    host_up <= 1'b1;
    cyc(20);
    check(32'(led), 32'h1);
    for (int i = 0; i < 7; i++) begin
      rdr(ra[i]);
      if (i < 5) check(rd, rv[i]);
      check(32'(rsp), 32'(i > 4 ? RESP_SLVERR : RESP_OKAY));
    end
    wr(ADR_RANGE, 32'h0000E4E4);
    check(32'(range_code), 32'hE4E4);
    cyc(1);
    check(32'(led), 32'h0);
    cyc(12);
    check(32'(led), 32'h1);
    $display("Test registers and light done");
    wr(ADR_CFG, 32'h300);
    wr(ADR_CMD, 32'h4);
    wr(ADR_CMD, 32'h4);
    for (int j = 0; j < 2; j++) begin
      poll(4, 1'b1);
      cyc(20);
      check(32'(starts), 32'(j + 1));
      rdr(ADR_SWDATA);
      check({16'h0, rd[15:0]}, 32'(16'h3000 + j));
    end
    $display("Test software conversion done");
    for (int i = 0; i < 3; i++) begin
      wr(ADR_CHMASK, 32'(mk[i]));
      wr(ADR_RATE, 32'(rt[i]));
      wr(ADR_CMD, 32'h1);
      poll(2, 1'b1);
      check(32'(rd[0]), 32'h0);
      wr(ADR_CMD, 32'h8);
      poll(2, 1'b0);
    end
    check(32'(starts), 32'h2);
    $display("Test refused starts done");
    wr(ADR_CHMASK, 32'h81);
    wr(ADR_RATE, 32'h64);
    wr(ADR_CFG, 32'h0);
    wr(ADR_CMD, 32'h1);
    poll(0, 1'b1);
    pl = led;
    tg = 0;
    repeat (40) begin
      @(posedge clk);
      if (led !== pl) tg++;
      pl = led;
    end
    check(32'(tg > 2), 32'h1);
    cyc(300);
    wr(ADR_CMD, 32'h2);
    poll(0, 1'b0);
    cyc(20);
    check(32'(led), 32'h1);
    rdr(ADR_STATUS);
    lvl = int'(rd[30:15]);
    check(32'(lvl > 0 && lvl % 2 == 0), 32'h1);
    check(32'(starts - 2), 32'(lvl / 2));
    for (int i = 0; i < lvl; i++) begin
      rdr(ADR_FIFO);
      check({16'h0, rd[15:0]}, {16'h0, i[0] ? 4'h7 : 4'h0, 12'(2 + i / 2)});
    end
    rdr(ADR_FIFO);
    check(rd, 32'h0);
    $display("Test paced scan done");
    for (int m = 0; m < 4; m++) begin
      trig <= m[0];
      wr(ADR_CFG, 32'(4 + 8 * m));
      s0 = starts;
      wr(ADR_CMD, 32'h1);
      poll(5, 1'b1);
      cyc(250);
      check(32'(starts), 32'(s0));
      trig <= ~m[0];
      cyc(250);
      check(32'(starts > s0), 32'h1);
      wr(ADR_CMD, 32'h2);
      poll(0, 1'b0);
    end
    $display("Test trigger modes done");
    wr(ADR_CFG, 32'h20);
    cyc(1);
    check(32'(sync_oe), 32'h1);
    host_up <= 1'b0;
    cyc(2);
    check(32'(led), 32'h0);
    host_up <= 1'b1;
    cyc(20);
    check(32'(led), 32'h1);
    wr(ADR_CMD, 32'h1);
    cyc(300);
    check(32'(syncs > 1), 32'h1);
    wr(ADR_CMD, 32'h2);
    poll(0, 1'b0);
    $display("Test sync and link done");
    wr(ADR_CFG, 32'h2);
    s0 = starts;
    wr(ADR_CMD, 32'h1);
    cyc(250);
    check(32'(starts), 32'(s0));
    repeat (3) begin
      sync_drv <= 1'b1;
      cyc(5);
      sync_drv <= 1'b0;
      cyc(95);
    end
    check(32'(starts), 32'(s0 + 3));
    wr(ADR_CMD, 32'h2);
    poll(0, 1'b0);
    $display("Test external clock done");
    wr(ADR_CFG, 32'h1);
    check(32'(rsp), 32'(RESP_OKAY));
    s0 = starts;
    wr(ADR_CMD, 32'h1);
    cyc(300);
    rdr(ADR_FIFO);
    check(32'(rsp), 32'(RESP_SLVERR));
    check(rd, 32'h0);
    wr(ADR_CMD, 32'h2);
    poll(0, 1'b0);
    rdr(ADR_FIFO);
    check({16'h0, rd[15:0]}, 32'(s0));
    $display("Test burst done");
    complete_run();
  end
  initial begin
    repeat (100000) @(posedge clk);
    errors++;
    complete_run();
  end
endmodule // testbench
